//--- core/civ_params.svh
// Constants for the interrupt vector logic: bit positions, vectors, resets
`ifndef CIV_PARAMS_SVH
`define CIV_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------
`define CIV_OFS_CPU_STATUS 4'h0
`define CIV_OFS_IRQ_STATUS 4'h1
`define CIV_OFS_TIMER_ZERO_STATUS 4'h2
`define CIV_OFS_PERIPH_FLAGS 4'h3
`define CIV_OFS_PERIPH_ENABLES 4'h4
`define CIV_OFS_TOP_OF_STACK 4'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CIV_BIT_GLINT_DIS 4
`define CIV_BIT_EXT_EN 0
`define CIV_BIT_TIMER_ZERO_EN 1
`define CIV_BIT_TCK_EN 2
`define CIV_BIT_PERIPH_GEN 3
`define CIV_BIT_EXT_FLAG 4
`define CIV_BIT_TIMER_ZERO_FLAG 5
`define CIV_BIT_TCK_FLAG 6
`define CIV_BIT_PERIPH_FLAG 7
`define CIV_BIT_EXT_EDGE 7
`define CIV_BIT_TCK_EDGE 6

// ----------------------------------------------------------------
// Vectors and reset values
// ----------------------------------------------------------------
`define CIV_VEC_EXT 16'h0008
`define CIV_VEC_TIMER_ZERO 16'h0010
`define CIV_VEC_TCK 16'h0018
`define CIV_VEC_PERIPH 16'h0020
`define CIV_RST_CPU_STATUS 8'h10
`define CIV_RST_IRQ_STATUS 8'h00
`define CIV_RST_TIMER_ZERO_STATUS 8'h00
`define CIV_RST_PERIPH_EN 8'h00
`define CIV_RST_STACK_PTR 4'h0

`endif

//--- core/civ_pkg.sv
// Types shared by the interrupt vector logic
package civ_pkg;
    typedef logic [7:0] civ_byte_t;
    typedef logic [15:0] civ_addr_t;
    typedef enum logic [1:0] {
        CIV_ST_IDLE = 2'b01,
        CIV_ST_ENTRY = 2'b10
    } civ_state_e;
endpackage : civ_pkg

//--- core/civ_vector_logic.sv
// Interrupt gathering, masking, priority and vectoring for the core
//
// Notes on behaviour
// - Global disable clear allows unmasked interrupts
// - Reset sets the global disable bit
// - Each source has its own enable
// - Peripheral global enable gates peripheral requests
// - Return clears disable, pops program counter
// - Taking interrupt sets global disable
// - Taking interrupt pushes return, loads vector
// - Highest priority pending source wins
// - External pin: vector 0008h, priority 1
// - Timer overflow: vector 0010h, priority 2
// - Timer clock pin: vector 0018h, priority 3
// - Peripherals: vector 0020h, lowest priority 4
// - Pin and timer flags set regardless of any enable
// - External pin edge chosen by select bit
// - External edge sets flag bit 4
// - Timer clock pin edge chosen by bit
// - Timer clock edge sets flag bit 6
// - Peripheral flag is read-only masked OR
// - Only return address is saved
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "civ_params.svh"

module civ_vector_logic
    import civ_pkg::*;
#(
    parameter int NUM_PERIPH = 8,
    parameter int STACK_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_irq_pin,
    input wire logic timer_clk_in_pin,
    input wire logic timer0_overflow,
    input wire logic [NUM_PERIPH-1:0] periph_flag_in,
    input wire logic irq_ack,
    input wire logic [15:0] return_addr,
    input wire logic return_from_interrupt,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic vector_load,
    output logic [15:0] new_pc,
    output logic [3:0] stack_ptr,
    output logic stack_overflow
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_PERIPH < 1 || NUM_PERIPH > 8) begin : g_bad_periph
        $error("NUM_PERIPH must be 1 to 8");
    end
    if (STACK_DEPTH != 16) begin : g_bad_depth
        $error("STACK_DEPTH must be 16 for a 4-bit pointer");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    civ_byte_t cpu_status_reg_q;
    civ_byte_t irq_ctrl_q;
    civ_byte_t timer0_status_reg_q;
    civ_byte_t periph_enable_regs_q;
    logic ext_pin_irq_flag_q;
    logic timer0_overflow_flag_q;
    logic timer_clk_pin_irq_flag_q;
    logic [2:0] ext_sync_q;
    logic [2:0] tck_sync_q;
    logic ext_level_q;
    logic tck_level_q;
    civ_addr_t stack_q [STACK_DEPTH];
    logic [3:0] sp_q;
    logic ovf_q;
    civ_state_e state_q;
    civ_addr_t vec_q;
    logic load_q;
    civ_addr_t pc_q;
    civ_byte_t rdata_q;

    logic global_irq_disable;
    logic periph_irq_global_enable;
    logic periph_irq_flag;
    logic ext_edge;
    logic tck_edge;
    logic ext_pend;
    logic timer_zero_pend;
    logic tck_pend;
    logic per_pend;
    logic take;
    civ_addr_t vec_d;
    logic wr_irq;
    civ_byte_t irq_status_ctrl_reg;

    assign global_irq_disable = cpu_status_reg_q[`CIV_BIT_GLINT_DIS];
    assign periph_irq_global_enable = irq_ctrl_q[`CIV_BIT_PERIPH_GEN];
    assign wr_irq = reg_wr && reg_addr == `CIV_OFS_IRQ_STATUS;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    // Three stages; an edge counts once stages two and three agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_sync_q <= 3'h0;
            tck_sync_q <= 3'h0;
            ext_level_q <= 1'b0;
            tck_level_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_irq_pin};
            tck_sync_q <= {tck_sync_q[1:0], timer_clk_in_pin};
            if (ext_sync_q[1] == ext_sync_q[2]) begin
                ext_level_q <= ext_sync_q[2];
            end
            if (tck_sync_q[1] == tck_sync_q[2]) begin
                tck_level_q <= tck_sync_q[2];
            end
        end
    end

    // Edge polarity per select bit; one edge gives one pulse
    always_comb begin
        logic ext_new;
        logic tck_new;
        ext_new = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2]
            : ext_level_q;
        tck_new = (tck_sync_q[1] == tck_sync_q[2]) ? tck_sync_q[2]
            : tck_level_q;
        if (timer0_status_reg_q[`CIV_BIT_EXT_EDGE]) begin
            ext_edge = ext_new && !ext_level_q;
        end else begin
            ext_edge = !ext_new && ext_level_q;
        end
        if (timer0_status_reg_q[`CIV_BIT_TCK_EDGE]) begin
            tck_edge = tck_new && !tck_level_q;
        end else begin
            tck_edge = !tck_new && tck_level_q;
        end
    end

    // ------------------------------------------------------------
    // Flags: set ignores enables and wins over a software clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_pin_irq_flag_q <= 1'b0;
            timer0_overflow_flag_q <= 1'b0;
            timer_clk_pin_irq_flag_q <= 1'b0;
        end else begin
            if (ext_edge) begin
                ext_pin_irq_flag_q <= 1'b1;
            end else if (wr_irq) begin
                ext_pin_irq_flag_q <= reg_wdata[`CIV_BIT_EXT_FLAG];
            end
            if (timer0_overflow) begin
                timer0_overflow_flag_q <= 1'b1;
            end else if (wr_irq) begin
                timer0_overflow_flag_q <= reg_wdata[`CIV_BIT_TIMER_ZERO_FLAG];
            end
            if (tck_edge) begin
                timer_clk_pin_irq_flag_q <= 1'b1;
            end else if (wr_irq) begin
                timer_clk_pin_irq_flag_q <= reg_wdata[`CIV_BIT_TCK_FLAG];
            end
        end
    end

    // Read-only peripheral summary
    assign periph_irq_flag =
        |(periph_flag_in & periph_enable_regs_q[NUM_PERIPH-1:0]);

    // Status/control byte as software sees it
    always_comb begin
        irq_status_ctrl_reg = irq_ctrl_q;
        irq_status_ctrl_reg[`CIV_BIT_EXT_FLAG] = ext_pin_irq_flag_q;
        irq_status_ctrl_reg[`CIV_BIT_TIMER_ZERO_FLAG] = timer0_overflow_flag_q;
        irq_status_ctrl_reg[`CIV_BIT_TCK_FLAG] = timer_clk_pin_irq_flag_q;
        irq_status_ctrl_reg[`CIV_BIT_PERIPH_FLAG] = periph_irq_flag;
    end

    // ------------------------------------------------------------
    // Masking and fixed priority
    // ------------------------------------------------------------
    assign ext_pend = ext_pin_irq_flag_q
        && irq_ctrl_q[`CIV_BIT_EXT_EN];
    assign timer_zero_pend = timer0_overflow_flag_q
        && irq_ctrl_q[`CIV_BIT_TIMER_ZERO_EN];
    assign tck_pend = timer_clk_pin_irq_flag_q
        && irq_ctrl_q[`CIV_BIT_TCK_EN];
    assign per_pend = periph_irq_flag && periph_irq_global_enable;

    // Lower vector wins; the peripheral vector comes last
    always_comb begin
        if (ext_pend) begin
            vec_d = `CIV_VEC_EXT;
        end else if (timer_zero_pend) begin
            vec_d = `CIV_VEC_TIMER_ZERO;
        end else if (tck_pend) begin
            vec_d = `CIV_VEC_TCK;
        end else begin
            vec_d = `CIV_VEC_PERIPH;
        end
    end

    // Request only while the global disable is clear
    assign irq_req = !global_irq_disable && state_q == CIV_ST_IDLE
        && (ext_pend || timer_zero_pend || tck_pend || per_pend);
    assign take = irq_req && irq_ack;
    assign irq_vector = vec_d;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Entry sets the disable; a same-cycle return loses to entry
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_status_reg_q <= `CIV_RST_CPU_STATUS;
            irq_ctrl_q <= `CIV_RST_IRQ_STATUS;
            timer0_status_reg_q <= `CIV_RST_TIMER_ZERO_STATUS;
            periph_enable_regs_q <= `CIV_RST_PERIPH_EN;
        end else begin
            if (reg_wr && reg_addr == `CIV_OFS_CPU_STATUS) begin
                cpu_status_reg_q <= reg_wdata;
            end
            if (take) begin
                cpu_status_reg_q[`CIV_BIT_GLINT_DIS] <= 1'b1;
            end else if (return_from_interrupt
                && state_q == CIV_ST_IDLE) begin
                cpu_status_reg_q[`CIV_BIT_GLINT_DIS] <= 1'b0;
            end
            if (wr_irq) begin
                irq_ctrl_q <= {4'h0, reg_wdata[3:0]};
            end
            if (reg_wr && reg_addr == `CIV_OFS_TIMER_ZERO_STATUS) begin
                timer0_status_reg_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `CIV_OFS_PERIPH_ENABLES) begin
                periph_enable_regs_q <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Hardware stack: holds only the return program counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_q <= `CIV_RST_STACK_PTR;
            ovf_q <= 1'b0;
            pc_q <= 16'h0000;
            load_q <= 1'b0;
            vec_q <= 16'h0000;
            state_q <= CIV_ST_IDLE;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= 16'h0000;
            end
        end else begin
            load_q <= 1'b0;
            case (state_q)
                CIV_ST_IDLE: begin
                    if (take) begin
                        stack_q[sp_q] <= return_addr;
                        sp_q <= sp_q + 4'h1;
                        ovf_q <= ovf_q || sp_q == 4'hf;
                        vec_q <= vec_d;
                        pc_q <= vec_d;
                        load_q <= 1'b1;
                        state_q <= CIV_ST_ENTRY;
                    end else if (return_from_interrupt) begin
                        pc_q <= stack_q[sp_q - 4'h1];
                        sp_q <= sp_q - 4'h1;
                        load_q <= 1'b1;
                    end
                end
                CIV_ST_ENTRY: begin
                    // One dead cycle mirrors the dummy fetch of entry
                    state_q <= CIV_ST_IDLE;
                end
                default: begin
                    state_q <= CIV_ST_IDLE;
                end
            endcase
        end
    end

    assign vector_load = load_q;
    assign new_pc = pc_q;
    assign stack_ptr = sp_q;
    assign stack_overflow = ovf_q;

    // ------------------------------------------------------------
    // Read port: data stands the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CIV_OFS_CPU_STATUS: rdata_q <= cpu_status_reg_q;
                `CIV_OFS_IRQ_STATUS: rdata_q <= irq_status_ctrl_reg;
                `CIV_OFS_TIMER_ZERO_STATUS: rdata_q <= timer0_status_reg_q;
                `CIV_OFS_PERIPH_FLAGS: rdata_q <=
                    8'(periph_flag_in);
                `CIV_OFS_PERIPH_ENABLES: rdata_q <= periph_enable_regs_q;
                `CIV_OFS_TOP_OF_STACK: rdata_q <= 8'(vec_q);
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    gate_block_a: assert property (@(posedge mclk) disable iff (rst)
        global_irq_disable |-> !irq_req)
        else $error("request while globally disabled");

    entry_disable_a: assert property (@(posedge mclk) disable iff (rst)
        take |=> global_irq_disable)
        else $error("entry did not set global disable");

    entry_vector_a: assert property (@(posedge mclk) disable iff (rst)
        take |=> vector_load && new_pc == $past(irq_vector))
        else $error("vector not loaded on entry");

    ext_priority_a: assert property (@(posedge mclk) disable iff (rst)
        ext_pend |-> irq_vector == 16'h0008)
        else $error("external pin lost priority");

    timer_zero_priority_a: assert property (@(posedge mclk) disable iff (rst)
        !ext_pend && timer_zero_pend |-> irq_vector == 16'h0010)
        else $error("timer vector wrong");

    tck_priority_a: assert property (@(posedge mclk) disable iff (rst)
        !ext_pend && !timer_zero_pend && tck_pend
        |-> irq_vector == 16'h0018)
        else $error("timer pin vector wrong");

    periph_gate_a: assert property (@(posedge mclk) disable iff (rst)
        !periph_irq_global_enable && !ext_pend && !timer_zero_pend && !tck_pend
        |-> !irq_req)
        else $error("peripheral passed global enable");

    return_pop_a: assert property (@(posedge mclk) disable iff (rst)
        return_from_interrupt && !take && state_q == CIV_ST_IDLE
        |=> !global_irq_disable && stack_ptr == $past(stack_ptr) - 4'h1)
        else $error("return did not pop and enable");

    flag_set_a: assert property (@(posedge mclk) disable iff (rst)
        timer0_overflow |=> timer0_overflow_flag_q)
        else $error("overflow flag not set");

endmodule : civ_vector_logic

//--- verif/civ_core_model.sv
// Core sequencer model that acknowledges requests and issues returns
module civ_core_model #(
    parameter logic [15:0] RET_PC = 16'h1234
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic [3:0] ack_wait,
    input wire logic ret_go,
    output logic irq_ack,
    output logic [15:0] return_addr,
    output logic return_from_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_q;

    // ------------------------------------------------------------
    // Acknowledge
    // ------------------------------------------------------------
    // Ack after a set number of request cycles, so slow cores are seen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            wait_q <= 4'h0;
        end else if (irq_req) begin
            irq_ack <= (wait_q == ack_wait);
            wait_q <= wait_q + 4'h1;
        end
    end

    // Return address is only true on the take edge; the inverse otherwise
    assign return_addr = irq_ack ? RET_PC : ~RET_PC;

    // One return pulse per command from the bench
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            return_from_interrupt <= 1'b0;
        end else begin
            return_from_interrupt <= ret_go;
        end
    end
endmodule : civ_core_model

//--- verif/tb_top.sv
// Self-checking testbench for the interrupt vector logic
`include "civ_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [15:0] RET_PC = 16'h1234;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_irq_pin = 1'b1;
    logic timer_clk_in_pin = 1'b0;
    logic timer0_overflow = 1'b0;
    logic [7:0] periph_flag_in = 8'h00;
    logic irq_ack;
    logic [15:0] return_addr;
    logic return_from_interrupt;
    logic irq_req;
    logic [15:0] irq_vector;
    logic vector_load;
    logic [15:0] new_pc;
    logic [3:0] stack_ptr;
    logic stack_overflow;
    logic [3:0] ack_wait = 4'h0;
    logic ret_go = 1'b0;
    int errors = 0;
    int compares = 0;
    logic [15:0] vec [4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020};
    logic [7:0] clr [4] = '{8'h6f, 8'h4f, 8'h0f, 8'h0f};

    always #5 mclk = ~mclk;

    civ_vector_logic u_civ_vector_logic (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_irq_pin(ext_irq_pin), .timer_clk_in_pin(timer_clk_in_pin),
        .timer0_overflow(timer0_overflow), .periph_flag_in(periph_flag_in),
        .irq_ack(irq_ack), .return_addr(return_addr),
        .return_from_interrupt(return_from_interrupt), .irq_req(irq_req),
        .irq_vector(irq_vector), .vector_load(vector_load), .new_pc(new_pc),
        .stack_ptr(stack_ptr), .stack_overflow(stack_overflow)
    );

    civ_core_model #(.RET_PC(RET_PC)) u_civ_core_model (
        .mclk(mclk), .rst(rst), .irq_req(irq_req), .ack_wait(ack_wait),
        .ret_go(ret_go), .irq_ack(irq_ack), .return_addr(return_addr),
        .return_from_interrupt(return_from_interrupt)
    );

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    // Combinational and registered outputs are looked at on the falling edge
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        @(negedge mclk);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: pc %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        @(negedge mclk);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic end_of_test();
        $display("Compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk8(reg_rdata, exp);
        @(posedge mclk);
    endtask : rd_chk

    // Bounded wait for a program counter load, then its value
    task automatic wait_load(input logic [15:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (vector_load !== 1'b1 && n < 40);
        if (vector_load !== 1'b1) begin
            errors++;
            $display("Error at %0t: no program counter load", $time);
            end_of_test();
        end else begin
            chk16(new_pc, exp);
        end
    endtask : wait_load

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(`CIV_OFS_CPU_STATUS, 8'h10);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h00);
        rd_chk(`CIV_OFS_TIMER_ZERO_STATUS, 8'h00);
        rd_chk(4'hf, 8'h00);
        // Falling pin edge and overflow with every enable off
        ext_irq_pin <= 1'b0;
        @(posedge mclk);
        timer0_overflow <= 1'b1;
        @(posedge mclk);
        timer0_overflow <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h30);
        chk1(irq_req, 1'b0);
        // Both pins on rising edges
        wr(`CIV_OFS_TIMER_ZERO_STATUS, 8'hc0);
        wr(`CIV_OFS_IRQ_STATUS, 8'h00);
        ext_irq_pin <= 1'b1;
        timer_clk_in_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h50);
        // Wrong edges leave the flags alone; one edge sets once
        wr(`CIV_OFS_IRQ_STATUS, 8'h00);
        ext_irq_pin <= 1'b0;
        timer_clk_in_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h00);
        // Peripheral flag is a masked OR; its request is gated by the group enable
        periph_flag_in <= 8'h01;
        wr(`CIV_OFS_PERIPH_ENABLES, 8'h00);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h00);
        wr(`CIV_OFS_PERIPH_ENABLES, 8'h01);
        rd_chk(`CIV_OFS_PERIPH_FLAGS, 8'h01);
        wr(`CIV_OFS_IRQ_STATUS, 8'h07);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h87);
        wr(`CIV_OFS_CPU_STATUS, 8'h00);
        repeat (3) @(posedge mclk);
        chk1(irq_req, 1'b0);
        wr(`CIV_OFS_CPU_STATUS, 8'h10);
        // All four sources pending while globally disabled
        wr(`CIV_OFS_IRQ_STATUS, 8'h7f);
        repeat (3) @(posedge mclk);
        chk1(irq_req, 1'b0);
        chk16(irq_vector, 16'h0008);
        wr(`CIV_OFS_CPU_STATUS, 8'h00);
        // Serve in priority order, clearing each source before return
        for (int k = 0; k < 4; k++) begin
            wait_load(vec[k]);
            chk8({4'h0, stack_ptr}, 8'h01);
            rd_chk(`CIV_OFS_CPU_STATUS, 8'h10);
            chk1(irq_req, 1'b0);
            wr(`CIV_OFS_IRQ_STATUS, clr[k]);
            if (k == 3) begin
                periph_flag_in <= 8'h00;
            end
            ack_wait <= 4'(3 * k + 2);
            @(posedge mclk);
            ret_go <= 1'b1;
            @(posedge mclk);
            ret_go <= 1'b0;
            wait_load(RET_PC);
            chk8({4'h0, stack_ptr}, 8'h00);
        end
        rd_chk(`CIV_OFS_CPU_STATUS, 8'h00);
        rd_chk(`CIV_OFS_TOP_OF_STACK, 8'h20);
        chk1(stack_overflow, 1'b0);
        // Disable first, then drop the enables
        wr(`CIV_OFS_CPU_STATUS, 8'h10);
        wr(`CIV_OFS_IRQ_STATUS, 8'h00);
        rd_chk(`CIV_OFS_IRQ_STATUS, 8'h00);
        end_of_test();
    end
endmodule : tb_top
